// >>> eicr_chk.sv
`timescale 1ns/1ps
module eicr_chk
  import eicr_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [3:0] EXT_IRQ_PIN,
  input wire logic CRYSTAL_WARMED_UP,
  input wire logic CRYSTAL_DISABLE,
  input wire logic [3:0] EXT_IRQ_REQ,
  input wire logic CLOCK_SOURCE_SELECT,
  input wire logic RING_MODE_STATUS,
  input wire logic CPU_STALL,
  input wire logic STOP_REFERENCE_KEEP
);
  // Data phase of a control register write
  logic wr_d;
  always_ff @(posedge CLK) begin
    wr_d <= NRST && HSEL && HTRANS[1] && HREADY && HWRITE && HADDR[7:0] == OFF_CTRL;
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  AST_PIN5_FALL: assert property ($fell(EXT_IRQ_PIN[3]) |-> ##[1:4] EXT_IRQ_REQ[3])
    else $error("pin5 edge lost");
  AST_PIN4_RISE: assert property ($rose(EXT_IRQ_PIN[2]) |-> ##[1:4] EXT_IRQ_REQ[2])
    else $error("pin4 edge lost");
  AST_PIN3_FALL: assert property ($fell(EXT_IRQ_PIN[1]) |-> ##[1:4] EXT_IRQ_REQ[1])
    else $error("pin3 edge lost");
  AST_PIN2_RISE: assert property ($rose(EXT_IRQ_PIN[0]) |-> ##[1:4] EXT_IRQ_REQ[0])
    else $error("pin2 edge lost");
  AST_STICKY: assert property (!wr_d |=> (~EXT_IRQ_REQ & $past(EXT_IRQ_REQ)) == 4'h0)
    else $error("flag dropped");
  AST_SW_FLAGS: assert property (wr_d |=> EXT_IRQ_REQ == $past(HWDATA[7:4]))
    else $error("flag write lost");
  AST_SEL0_RING: assert property (!CLOCK_SOURCE_SELECT |-> RING_MODE_STATUS)
    else $error("ring status wrong");
  AST_SEL_GUARD: assert property ($rose(CLOCK_SOURCE_SELECT) |->
    $past(CRYSTAL_WARMED_UP, 3) && !$past(CRYSTAL_DISABLE)) else $error("select set");
  AST_SEL_CLR: assert property (wr_d && !HWDATA[3] |=> !CLOCK_SOURCE_SELECT)
    else $error("select not cleared");
  AST_STALL_END: assert property ((CPU_STALL && CRYSTAL_WARMED_UP)[*3] |=> !CPU_STALL)
    else $error("stall too long");
  AST_REF_KEEP: assert property ($changed(STOP_REFERENCE_KEEP) |-> $past(wr_d))
    else $error("ref keep moved");
endmodule
bind eicr_top eicr_chk u_chk (.CLK(CLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
  .EXT_IRQ_PIN(EXT_IRQ_PIN), .CRYSTAL_WARMED_UP(CRYSTAL_WARMED_UP),
  .CRYSTAL_DISABLE(CRYSTAL_DISABLE), .EXT_IRQ_REQ(EXT_IRQ_REQ),
  .CLOCK_SOURCE_SELECT(CLOCK_SOURCE_SELECT), .RING_MODE_STATUS(RING_MODE_STATUS),
  .CPU_STALL(CPU_STALL), .STOP_REFERENCE_KEEP(STOP_REFERENCE_KEEP));

// >>> eicr_osc.sv
`timescale 1ns/1ps
module eicr_osc #(
  parameter int WARM_CYCLES = 20
) (
  input wire logic clk,
  input wire logic stop_enter,
  input wire logic stop_resume,
  output logic warm
);
  int cnt = 0;
  initial warm = 1'b1;
  // Crystal halts in stop and needs a warmup after resume
  always @(posedge clk) begin
    if (stop_enter) begin
      warm <= 1'b0;
      cnt <= 0;
    end else if (!warm && stop_resume) begin
      cnt <= 1;
    end else if (cnt != 0 && cnt < WARM_CYCLES) begin
      cnt <= cnt + 1;
    end else if (cnt == WARM_CYCLES) begin
      warm <= 1'b1;
    end
  end
endmodule

// >>> eicr_pkg.sv
package eicr_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_KEY = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_LINK_STATUS = 8'h14;

  // ----------------------------------------------------------------
  // Field positions of external_irq_flag_clock_ctrl
  // ----------------------------------------------------------------
  localparam int BIT_FLAG_LO = 4;
  localparam int BIT_CLOCK_SOURCE_SELECT = 3;
  localparam int BIT_RING_MODE_STATUS = 2;
  localparam int BIT_RESUME_SOURCE_SELECT = 1;
  localparam int BIT_STOP_REFERENCE_KEEP = 0;

  // Pins 2..5 map to vector bits 0..3; a one marks a falling-edge pin
  localparam logic [3:0] FALL_EDGE_MASK = 4'hA;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] RST_FLAGS = 4'h0;
  localparam logic RST_CLOCK_SOURCE_SELECT = 1'b1;
  localparam logic RST_RING_MODE_STATUS = 1'b0;
  localparam logic RST_RESUME_SOURCE_SELECT = 1'b0;
  localparam logic RST_STOP_REFERENCE_KEEP = 1'b0;

  // ----------------------------------------------------------------
  // Protected write sequence
  // ----------------------------------------------------------------
  localparam logic [7:0] KEY_FIRST = 8'hAA;
  localparam logic [7:0] KEY_SECOND = 8'h55;
  localparam int KEY_OPEN_CYCLES = 8;

  // ----------------------------------------------------------------
  // Interrupt status bits
  // ----------------------------------------------------------------
  localparam int IRQ_W = 6;
  localparam int IRQ_BIT_RESUMED = 4;
  localparam int IRQ_BIT_REFUSED = 5;

  typedef enum logic [3:0] {
    EICR_RUN = 4'h1,
    EICR_STOP = 4'h2,
    EICR_HOLD = 4'h4,
    EICR_RING_WARM = 4'h8
  } eicr_clk_state_t;

  typedef struct packed {
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_s3;
    logic [1:0] fill;
    logic warm_s1;
    logic warm_s2;
    logic [3:0] flags;
    logic clock_source_select;
    logic ring_mode_status;
    logic resume_source_select;
    logic stop_reference_keep;
    logic key_armed;
    logic [3:0] key_count;
    eicr_clk_state_t clk_state;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;
    logic dp_valid;
    logic dp_write;
    logic [ADDR_W-1:0] dp_addr;
    logic [31:0] rdata;
  } eicr_state_t;

endpackage

// >>> eicr_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e); end end
module eicr_tb_top
  import eicr_pkg::*;
;
  logic clk = 1'b0, nrst = 1'b0, por = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic stop_in = 1'b0, stop_out = 1'b0, xdis = 1'b0, warm;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [3:0] pin = FALL_EDGE_MASK, req;
  logic hready, hresp, sel, ring, stall, keep, irq;
  int n_errors = 0, num_checks = 0;
  always #20 clk = ~clk;
  eicr_top u_dut (.CLK(clk), .NRST(nrst), .POR_FLAG(por), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .EXT_IRQ_PIN(pin),
    .CRYSTAL_WARMED_UP(warm), .CRYSTAL_DISABLE(xdis), .STOP_ENTER(stop_in),
    .STOP_RESUME(stop_out), .EXT_IRQ_REQ(req), .CLOCK_SOURCE_SELECT(sel),
    .RING_MODE_STATUS(ring), .CPU_STALL(stall), .STOP_REFERENCE_KEEP(keep), .IRQ(irq));
  eicr_osc #(.WARM_CYCLES(20)) u_osc (.clk(clk), .stop_enter(stop_in),
    .stop_resume(stop_out), .warm(warm));
  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(rd, e)
    `CHK(hresp, 1'b0)
  endtask
  task stop_cycle();
    stop_in <= 1'b1;
    wt(1);
    stop_in <= 1'b0;
    wt(3);
    stop_out <= 1'b1;
    wt(1);
    stop_out <= 1'b0;
    wt(2);
  endtask
  task summarize();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    wt(20000);
    n_errors++;
    summarize();
  end
  initial begin
    wt(10);
    nrst <= 1'b1;
    por <= 1'b0;
    wt(4);
    rd_chk(OFF_CTRL, 32'h08);
    wr(8'h18, 32'hFF);
    rd_chk(8'h18, 32'h0);
    for (int k = 0; k < 4; k++) begin
      pin[k] <= ~pin[k];
      wt(6);
      rd_chk(OFF_CTRL, 32'h08 | (32'h10 << k));
      pin[k] <= ~pin[k];
      wr(OFF_CTRL, 32'h08);
      wt(6);
      rd_chk(OFF_CTRL, 32'h08);
    end
    rd_chk(OFF_IRQ_STATUS, 32'h0F);
    `CHK(irq, 1'b0)
    wr(OFF_IRQ_ENABLE, 32'h01);
    wt(1);
    `CHK(irq, 1'b1)
    wr(OFF_IRQ_CLEAR, 32'h01);
    wt(1);
    `CHK(irq, 1'b0)
    wr(OFF_IRQ_ENABLE, 32'h3F);
    wr(OFF_CTRL, 32'hF8);
    wt(1);
    `CHK(req, 4'hF)
    rd_chk(OFF_CTRL, 32'hF8);
    wr(OFF_CTRL, 32'h08);
    wt(1);
    `CHK(req, 4'h0)
    wr(OFF_IRQ_CLEAR, 32'h3F);
    wr(OFF_CTRL, 32'h00);
    rd_chk(OFF_CTRL, 32'h04);
    `CHK(sel, 1'b0)
    xdis <= 1'b1;
    wr(OFF_CTRL, 32'h08);
    rd_chk(OFF_CTRL, 32'h04);
    rd_chk(OFF_IRQ_STATUS, 32'h20);
    xdis <= 1'b0;
    wr(OFF_CTRL, 32'h08);
    rd_chk(OFF_CTRL, 32'h08);
    wr(OFF_CTRL, 32'h09);
    rd_chk(OFF_CTRL, 32'h08);
    wr(OFF_KEY, {24'h0, KEY_FIRST});
    wr(OFF_KEY, {24'h0, KEY_SECOND});
    rd_chk(OFF_KEY, 32'h01);
    wr(OFF_CTRL, 32'h09);
    rd_chk(OFF_CTRL, 32'h09);
    `CHK(keep, 1'b1)
    stop_cycle();
    `CHK(stall, 1'b1)
    for (int n = 0; n < 100 && stall === 1'b1; n++) wt(1);
    `CHK(warm, 1'b1)
    `CHK(ring, 1'b0)
    rd_chk(OFF_IRQ_STATUS, 32'h30);
    rd_chk(OFF_LINK_STATUS, 32'h01);
    wr(OFF_CTRL, 32'h0A);
    stop_cycle();
    `CHK(stall, 1'b0)
    `CHK(ring, 1'b1)
    `CHK(sel, 1'b1)
    rd_chk(OFF_LINK_STATUS, 32'h08);
    wt(40);
    `CHK(ring, 1'b0)
    rd_chk(OFF_CTRL, 32'h0B);
    wr(OFF_CTRL, 32'h02);
    rd_chk(OFF_CTRL, 32'h07);
    nrst <= 1'b0;
    wt(3);
    nrst <= 1'b1;
    wt(4);
    rd_chk(OFF_CTRL, 32'h06);
    summarize();
  end
endmodule

// >>> eicr_top.sv
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Function
// RULE1: Falling edge on pin 5 sets bit 7
// RULE2: Rising edge on pin 4 sets bit 6
// RULE3: Falling edge on pin 3 sets bit 5
// RULE4: Rising edge on pin 2 sets bit 4
// RULE5: Flags cleared only by software writing zero
// RULE6: Software writing one sets flag, raising request
// RULE7: Bit 3: one crystal, zero ring
// RULE8: Select reads inverse of ring status, except warmup
// RULE9: Setting select needs warmed crystal, not disabled
// RULE10: Software clears select before disabling crystal
// RULE11: Select set by power-on reset, else kept
// RULE12: Clearing select always picks ring oscillator
// RULE13: Bit 2 reports ring oscillator running
// RULE14: Ring status, resume select cleared at power-on only
// RULE15: Resume select zero stalls until crystal warm
// RULE16: Resume select one runs ring, then switches
// RULE17: Bit 0 keeps reference on during stop
// RULE18: Bit 0 written only via protected sequence
// RULE19: Pins synchronised, edges from consecutive samples
module eicr_top
  import eicr_pkg::*;
#(
  parameter int KEY_WINDOW = KEY_OPEN_CYCLES
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic POR_FLAG,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [3:0] EXT_IRQ_PIN,
  input wire logic CRYSTAL_WARMED_UP,
  input wire logic CRYSTAL_DISABLE,
  input wire logic STOP_ENTER,
  input wire logic STOP_RESUME,
  output logic [3:0] EXT_IRQ_REQ,
  output logic CLOCK_SOURCE_SELECT,
  output logic RING_MODE_STATUS,
  output logic CPU_STALL,
  output logic STOP_REFERENCE_KEEP,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  generate
    if (KEY_WINDOW < 1 || KEY_WINDOW > 15) begin : g_bad_window
      $error("KEY_WINDOW must lie between 1 and 15");
    end
  endgenerate

  localparam logic [3:0] KEY_WINDOW_CNT = 4'(KEY_WINDOW);

  eicr_state_t st;
  eicr_state_t next_st;

  logic [3:0] pin_edge;
  logic addr_phase;
  logic wr_any;
  logic wr_ctrl;
  logic wr_key;
  logic wr_clear;
  logic wr_enable;
  logic warm;
  logic key_open;
  logic [7:0] wbyte;
  logic [7:0] ctrl_read;
  logic [31:0] read_mux;

  // ----------------------------------------------------------------
  // Pin edge detection
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_edge
      if (FALL_EDGE_MASK[gi]) begin : g_fall
        assign pin_edge[gi] = (st.fill == 2'h3) & st.pin_s3[gi] & ~st.pin_s2[gi]; // RULE1 RULE3
      end else begin : g_rise
        assign pin_edge[gi] = (st.fill == 2'h3) & ~st.pin_s3[gi] & st.pin_s2[gi]; // RULE2 RULE4
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign addr_phase = HSEL & HTRANS[1] & HREADY;
  assign wr_any = st.dp_valid & st.dp_write;
  assign wr_ctrl = wr_any & (st.dp_addr == OFF_CTRL);
  assign wr_key = wr_any & (st.dp_addr == OFF_KEY);
  assign wr_clear = wr_any & (st.dp_addr == OFF_IRQ_CLEAR);
  assign wr_enable = wr_any & (st.dp_addr == OFF_IRQ_ENABLE);
  assign wbyte = HWDATA[7:0];
  assign warm = st.warm_s2;
  assign key_open = st.key_count != 4'h0;

  assign ctrl_read = {st.flags, st.clock_source_select, st.ring_mode_status,
                      st.resume_source_select, st.stop_reference_keep};

  always_comb begin
    read_mux = 32'h0000_0000;
    case (HADDR[ADDR_W-1:0])
      OFF_CTRL: read_mux = {24'h00_0000, ctrl_read};
      OFF_KEY: read_mux = {31'h0000_0000, key_open};
      OFF_IRQ_STATUS: read_mux = {26'h000_0000, st.irq_status};
      OFF_IRQ_ENABLE: read_mux = {26'h000_0000, st.irq_enable};
      OFF_LINK_STATUS: read_mux = {28'h000_0000, st.clk_state};
      default: read_mux = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    // Two-stage synchronisers plus a compare stage
    next_st.pin_s1 = EXT_IRQ_PIN; // RULE19
    next_st.pin_s2 = st.pin_s1; // RULE19
    next_st.pin_s3 = st.pin_s2; // RULE19
    next_st.warm_s1 = CRYSTAL_WARMED_UP;
    next_st.warm_s2 = st.warm_s1;
    if (st.fill != 2'h3) begin
      next_st.fill = st.fill + 2'h1;
    end

    // Edge flags: write stores, edge sets, edge beats a clearing write
    if (wr_ctrl) begin
      next_st.flags = wbyte[7:BIT_FLAG_LO]; // RULE5 RULE6
    end
    next_st.flags = next_st.flags | pin_edge; // RULE1 RULE2 RULE3 RULE4

    // Clock source select
    if (wr_ctrl) begin
      if (!wbyte[BIT_CLOCK_SOURCE_SELECT]) begin
        next_st.clock_source_select = 1'b0; // RULE12
      end else if (warm && !CRYSTAL_DISABLE) begin
        next_st.clock_source_select = 1'b1; // RULE7 RULE9
      end
      next_st.resume_source_select = wbyte[BIT_RESUME_SOURCE_SELECT];
    end

    // Protected write sequence
    if (key_open) begin
      next_st.key_count = st.key_count - 4'h1;
    end
    if (wr_key) begin
      next_st.key_armed = (wbyte == KEY_FIRST);
      if (st.key_armed && wbyte == KEY_SECOND) begin
        next_st.key_count = KEY_WINDOW_CNT;
      end
    end else if (wr_any) begin
      next_st.key_armed = 1'b0;
    end
    if (wr_ctrl && key_open) begin
      next_st.stop_reference_keep = wbyte[BIT_STOP_REFERENCE_KEEP]; // RULE17 RULE18
      next_st.key_count = 4'h0;
    end

    // Stop and resume sequencing
    case (st.clk_state)
      EICR_RUN: begin
        if (STOP_ENTER) begin
          next_st.clk_state = EICR_STOP;
        end
      end
      EICR_STOP: begin
        if (STOP_RESUME) begin
          if (st.resume_source_select) begin
            next_st.clk_state = EICR_RING_WARM; // RULE16
          end else begin
            next_st.clk_state = EICR_HOLD; // RULE15
          end
        end
      end
      EICR_HOLD: begin
        if (warm) begin
          next_st.clk_state = EICR_RUN; // RULE15
        end
      end
      EICR_RING_WARM: begin
        if (warm) begin
          next_st.clk_state = EICR_RUN; // RULE16
        end
      end
      default: next_st.clk_state = EICR_RUN;
    endcase

    // Ring status is the inverse of the select except during a ring resume
    if (next_st.clk_state == EICR_RING_WARM) begin
      next_st.ring_mode_status = 1'b1; // RULE13 RULE16
    end else begin
      next_st.ring_mode_status = ~next_st.clock_source_select; // RULE8 RULE13
    end

    // Interrupt status: clear then set, so a new event wins
    if (wr_clear) begin
      next_st.irq_status = st.irq_status & ~HWDATA[IRQ_W-1:0];
    end
    next_st.irq_status[3:0] = next_st.irq_status[3:0] | pin_edge;
    if ((st.clk_state == EICR_HOLD || st.clk_state == EICR_RING_WARM) && warm) begin
      next_st.irq_status[IRQ_BIT_RESUMED] = 1'b1;
    end
    if (wr_ctrl && wbyte[BIT_CLOCK_SOURCE_SELECT] && !st.clock_source_select
        && !(warm && !CRYSTAL_DISABLE)) begin
      next_st.irq_status[IRQ_BIT_REFUSED] = 1'b1; // RULE9
    end
    if (wr_enable) begin
      next_st.irq_enable = HWDATA[IRQ_W-1:0];
    end

    // Bus address phase and read data
    next_st.dp_valid = addr_phase;
    if (addr_phase) begin
      next_st.dp_write = HWRITE;
      next_st.dp_addr = HADDR[ADDR_W-1:0];
      if (!HWRITE) begin
        next_st.rdata = read_mux;
      end
    end

    // Synchronous reset; power-on reset also restores clock fields
    if (!NRST) begin
      next_st.fill = 2'h0;
      next_st.flags = RST_FLAGS;
      next_st.stop_reference_keep = RST_STOP_REFERENCE_KEEP;
      next_st.key_armed = 1'b0;
      next_st.key_count = 4'h0;
      next_st.clk_state = EICR_RUN;
      next_st.irq_status = '0;
      next_st.irq_enable = '0;
      next_st.dp_valid = 1'b0;
      next_st.dp_write = 1'b0;
      next_st.dp_addr = '0;
      next_st.rdata = 32'h0000_0000;
      next_st.clock_source_select = st.clock_source_select; // RULE11
      next_st.ring_mode_status = st.ring_mode_status; // RULE14
      next_st.resume_source_select = st.resume_source_select; // RULE14
      if (POR_FLAG) begin
        next_st.clock_source_select = RST_CLOCK_SOURCE_SELECT; // RULE11
        next_st.ring_mode_status = RST_RING_MODE_STATUS; // RULE14
        next_st.resume_source_select = RST_RESUME_SOURCE_SELECT; // RULE14
      end
    end
  end

  always_ff @(posedge CLK) begin
    st <= next_st;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign HRDATA = st.rdata;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign EXT_IRQ_REQ = st.flags; // RULE6
  assign CLOCK_SOURCE_SELECT = st.clock_source_select; // RULE7
  assign RING_MODE_STATUS = st.ring_mode_status;
  assign CPU_STALL = (st.clk_state == EICR_HOLD); // RULE15
  assign STOP_REFERENCE_KEEP = st.stop_reference_keep; // RULE17
  assign IRQ = |(st.irq_status & st.irq_enable);

endmodule
